// ==== rtl/dual_comparator_control.sv ====
// Register file and top level for the two comparator channels
`timescale 1ns/1ps
`include "cmp_map.svh"
module dual_comparator_control
	import cmp_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	input wire logic global_irq_en,
	input wire logic cmp_zero_irq_src_en,
	input wire logic cmp_one_irq_src_en,
	input wire logic cmp_zero_core_in,
	input wire logic cmp_one_core_in,
	output logic cmp_zero_power_en,
	output logic cmp_one_power_en,
	output resp_mode_e cmp_zero_response_sel,
	output resp_mode_e cmp_one_response_sel,
	output hyst_mv_t cmp_zero_pos_hyst_mv,
	output hyst_mv_t cmp_zero_neg_hyst_mv,
	output hyst_mv_t cmp_one_pos_hyst_mv,
	output hyst_mv_t cmp_one_neg_hyst_mv,
	output logic cmp_zero_latched_out,
	output logic cmp_one_latched_out,
	output logic cmp_zero_raw_out,
	output logic cmp_one_raw_out,
	output logic cmp_zero_irq,
	output logic cmp_one_irq
);
	localparam int NUM_CMP = 2;
	localparam logic [7:0] CTRL_RST = `CTRL_RESET;
	localparam logic [7:0] MODE_RST = `MODE_RESET;

	// ----------------------------------------
	// Per-channel state, index 0 is comparator zero
	// ----------------------------------------
	logic [NUM_CMP-1:0] enable_q;
	hyst_sel_e pos_hyst_q [NUM_CMP];
	hyst_sel_e neg_hyst_q [NUM_CMP];
	logic [NUM_CMP-1:0] rise_ie_q;
	logic [NUM_CMP-1:0] fall_ie_q;
	resp_mode_e resp_q [NUM_CMP];
	logic [NUM_CMP-1:0] core_in;
	logic [NUM_CMP-1:0] src_en;
	logic [NUM_CMP-1:0] raw_out;
	logic [NUM_CMP-1:0] latched_out;
	logic [NUM_CMP-1:0] irq;
	logic [NUM_CMP-1:0] ctrl_hit;
	logic [NUM_CMP-1:0] mode_hit;
	logic [7:0] ctrl_view [NUM_CMP];
	logic [7:0] mode_view [NUM_CMP];
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;

	assign core_in = {cmp_one_core_in, cmp_zero_core_in};
	assign src_en = {cmp_one_irq_src_en, cmp_zero_irq_src_en};

	// ----------------------------------------
	// Channels
	// ----------------------------------------
	generate
		for (genvar i = 0; i < NUM_CMP; i++)
		begin : g_cmp
			localparam logic [7:0] CTRL_ADDR =
				(i == 0) ? `CMP_ZERO_CTRL_ADDR : `CMP_ONE_CTRL_ADDR;
			localparam logic [7:0] MODE_ADDR =
				(i == 0) ? `CMP_ZERO_MODE_ADDR : `CMP_ONE_MODE_ADDR;

			cmp_ctrl_if ctl ();

			wire ctrl_wr = sfr_wr & (sfr_addr == CTRL_ADDR);
			wire mode_wr = sfr_wr & (sfr_addr == MODE_ADDR);

			assign ctrl_hit[i] = (sfr_addr == CTRL_ADDR);
			assign mode_hit[i] = (sfr_addr == MODE_ADDR);

			// Both flags share one write; each takes its own data bit
			assign ctl.flag_wr = ctrl_wr;
			assign ctl.flag_wdata = {sfr_wdata[`CTRL_RISE_BIT], sfr_wdata[`CTRL_FALL_BIT]};
			assign ctl.enable = enable_q[i];
			assign ctl.rise_ie = rise_ie_q[i];
			assign ctl.fall_ie = fall_ie_q[i];

			// Readback of the control register
			assign ctrl_view[i] = {enable_q[i], ctl.state, ctl.rise_flag, ctl.fall_flag,
				pos_hyst_q[i], neg_hyst_q[i]};
			// Reserved bit reads 1, unused bits read 0
			assign mode_view[i] = {1'b1, 1'b0, rise_ie_q[i], fall_ie_q[i],
				2'b00, resp_q[i]};

			always_ff @(posedge sys_clk)
			begin
				if (!resetn)
				begin
					enable_q[i] <= CTRL_RST[`CTRL_EN_BIT];
					pos_hyst_q[i] <= hyst_sel_e'(CTRL_RST[`CTRL_HYP_HI:`CTRL_HYP_LO]);
					neg_hyst_q[i] <= hyst_sel_e'(CTRL_RST[`CTRL_HYN_HI:`CTRL_HYN_LO]);
				end
				else if (ctrl_wr)
				begin
					enable_q[i] <= sfr_wdata[`CTRL_EN_BIT];
					pos_hyst_q[i] <= hyst_sel_e'(sfr_wdata[`CTRL_HYP_HI:`CTRL_HYP_LO]);
					neg_hyst_q[i] <= hyst_sel_e'(sfr_wdata[`CTRL_HYN_HI:`CTRL_HYN_LO]);
				end
			end

			always_ff @(posedge sys_clk)
			begin
				if (!resetn)
				begin
					rise_ie_q[i] <= MODE_RST[`MODE_RIE_BIT];
					fall_ie_q[i] <= MODE_RST[`MODE_FIE_BIT];
					resp_q[i] <= resp_mode_e'(MODE_RST[`MODE_MD_HI:`MODE_MD_LO]);
				end
				else if (mode_wr)
				begin
					rise_ie_q[i] <= sfr_wdata[`MODE_RIE_BIT];
					fall_ie_q[i] <= sfr_wdata[`MODE_FIE_BIT];
					resp_q[i] <= resp_mode_e'(sfr_wdata[`MODE_MD_HI:`MODE_MD_LO]);
				end
			end

			// Same channel logic for both instances
			cmp_channel u_channel (
				.sys_clk(sys_clk),
				.resetn(resetn),
				.core_in(core_in[i]),
				.irq_src_en(src_en[i]),
				.global_irq_en(global_irq_en),
				.ctl(ctl.chan),
				.raw_out(raw_out[i]),
				.latched_out(latched_out[i]),
				.irq(irq[i])
			);
		end
	endgenerate

	// ----------------------------------------
	// Analog core controls
	// ----------------------------------------
	// The core itself applies the thresholds; the input arrives already hysteretic
	assign cmp_zero_pos_hyst_mv = hyst_mv(pos_hyst_q[0]);
	assign cmp_zero_neg_hyst_mv = hyst_mv(neg_hyst_q[0]);
	assign cmp_one_pos_hyst_mv = hyst_mv(pos_hyst_q[1]);
	assign cmp_one_neg_hyst_mv = hyst_mv(neg_hyst_q[1]);
	// Enable low puts the core in shutdown
	assign cmp_zero_power_en = enable_q[0];
	assign cmp_one_power_en = enable_q[1];
	assign cmp_zero_response_sel = resp_q[0];
	assign cmp_one_response_sel = resp_q[1];

	// ----------------------------------------
	// Digital outputs
	// ----------------------------------------
	assign cmp_zero_latched_out = latched_out[0];
	assign cmp_one_latched_out = latched_out[1];
	assign cmp_zero_raw_out = raw_out[0];
	assign cmp_one_raw_out = raw_out[1];
	assign cmp_zero_irq = irq[0];
	assign cmp_one_irq = irq[1];

	// ----------------------------------------
	// Register read
	// ----------------------------------------
	// Unmapped addresses read as zero
	wire [7:0] sel_ctrl0 = ctrl_hit[0] ? ctrl_view[0] : 8'h00;
	wire [7:0] sel_ctrl1 = ctrl_hit[1] ? ctrl_view[1] : 8'h00;
	wire [7:0] sel_mode0 = mode_hit[0] ? mode_view[0] : 8'h00;
	wire [7:0] sel_mode1 = mode_hit[1] ? mode_view[1] : 8'h00;
	assign rdata_d = sel_ctrl0 | sel_ctrl1 | sel_mode0 | sel_mode1;
	assign sfr_rdata = rdata_q;

	// Read data held until the next read so the core may sample late
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			rdata_q <= 8'h00;
		else if (sfr_rd)
			rdata_q <= rdata_d;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_mode_rsvd;
		@(posedge sys_clk) disable iff (!resetn)
		sfr_rd && (sfr_addr == `CMP_ZERO_MODE_ADDR || sfr_addr == `CMP_ONE_MODE_ADDR)
		|=> sfr_rdata[`MODE_RSVD_BIT] && sfr_rdata[6:6] == 1'b0;
	endproperty
	a_mode_rsvd: assert property (p_mode_rsvd) else $error("mode reserved bits wrong");

	property p_mode_reset;
		@(posedge sys_clk)
		!resetn |=> resp_q[0] == RESP_MODE2 && resp_q[1] == RESP_MODE2;
	endproperty
	a_mode_reset: assert property (p_mode_reset) else $error("mode reset not 10");

	property p_disable;
		@(posedge sys_clk) disable iff (!resetn)
		sfr_wr && sfr_addr == `CMP_ZERO_CTRL_ADDR && !sfr_wdata[`CTRL_EN_BIT]
		|=> !cmp_zero_power_en ##1 !cmp_zero_latched_out;
	endproperty
	a_disable: assert property (p_disable) else $error("disable not honoured");

	property p_state_read;
		@(posedge sys_clk) disable iff (!resetn)
		sfr_rd && sfr_addr == `CMP_ONE_CTRL_ADDR
		|=> sfr_rdata[`CTRL_STATE_BIT] == $past(cmp_one_latched_out);
	endproperty
	a_state_read: assert property (p_state_read) else $error("state bit wrong");

	property p_pos_max;
		@(posedge sys_clk) disable iff (!resetn)
		sfr_wr && sfr_addr == `CMP_ZERO_CTRL_ADDR
		&& sfr_wdata[`CTRL_HYP_HI:`CTRL_HYP_LO] == 2'b11
		|=> cmp_zero_pos_hyst_mv == `HYST_MV_L3;
	endproperty
	a_pos_max: assert property (p_pos_max) else $error("positive hysteresis not max");

	property p_neg_lvl1;
		@(posedge sys_clk) disable iff (!resetn)
		sfr_wr && sfr_addr == `CMP_ONE_CTRL_ADDR
		&& sfr_wdata[`CTRL_HYN_HI:`CTRL_HYN_LO] == 2'b01
		|=> cmp_one_neg_hyst_mv == `HYST_MV_L1;
	endproperty
	a_neg_lvl1: assert property (p_neg_lvl1) else $error("negative hysteresis wrong");

	property p_unmapped;
		@(posedge sys_clk) disable iff (!resetn)
		sfr_rd && ctrl_hit == 2'b00 && mode_hit == 2'b00 |=> sfr_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

	property p_disable_one;
		@(posedge sys_clk) disable iff (!resetn)
		sfr_wr && sfr_addr == `CMP_ONE_CTRL_ADDR && !sfr_wdata[`CTRL_EN_BIT]
		|=> !cmp_one_power_en ##1 (!cmp_one_latched_out && !cmp_one_raw_out);
	endproperty
	a_disable_one: assert property (p_disable_one) else $error("disable one ignored");

	property p_pos_max_one;
		@(posedge sys_clk) disable iff (!resetn)
		sfr_wr && sfr_addr == `CMP_ONE_CTRL_ADDR
		&& sfr_wdata[`CTRL_HYP_HI:`CTRL_HYP_LO] == 2'b11
		|=> cmp_one_pos_hyst_mv == `HYST_MV_L3;
	endproperty
	a_pos_max_one: assert property (p_pos_max_one) else $error("positive max wrong");

	property p_neg_max_zero;
		@(posedge sys_clk) disable iff (!resetn)
		sfr_wr && sfr_addr == `CMP_ZERO_CTRL_ADDR
		&& sfr_wdata[`CTRL_HYN_HI:`CTRL_HYN_LO] == 2'b11
		|=> cmp_zero_neg_hyst_mv == `HYST_MV_L3;
	endproperty
	a_neg_max_zero: assert property (p_neg_max_zero) else $error("negative max wrong");

	property p_pos_off_one;
		@(posedge sys_clk) disable iff (!resetn)
		sfr_wr && sfr_addr == `CMP_ONE_CTRL_ADDR
		&& sfr_wdata[`CTRL_HYP_HI:`CTRL_HYP_LO] == 2'b00
		|=> cmp_one_pos_hyst_mv == `HYST_MV_L0;
	endproperty
	a_pos_off_one: assert property (p_pos_off_one) else $error("positive off wrong");

	property p_neg_lvl2_zero;
		@(posedge sys_clk) disable iff (!resetn)
		sfr_wr && sfr_addr == `CMP_ZERO_CTRL_ADDR
		&& sfr_wdata[`CTRL_HYN_HI:`CTRL_HYN_LO] == 2'b10
		|=> cmp_zero_neg_hyst_mv == `HYST_MV_L2;
	endproperty
	a_neg_lvl2_zero: assert property (p_neg_lvl2_zero) else $error("negative level wrong");

	property p_pos_lvl1_zero;
		@(posedge sys_clk) disable iff (!resetn)
		sfr_wr && sfr_addr == `CMP_ZERO_CTRL_ADDR
		&& sfr_wdata[`CTRL_HYP_HI:`CTRL_HYP_LO] == 2'b01
		|=> cmp_zero_pos_hyst_mv == `HYST_MV_L1;
	endproperty
	a_pos_lvl1_zero: assert property (p_pos_lvl1_zero) else $error("positive level wrong");

	property p_en_read;
		@(posedge sys_clk) disable iff (!resetn)
		sfr_rd && sfr_addr == `CMP_ZERO_CTRL_ADDR
		|=> sfr_rdata[`CTRL_EN_BIT] == $past(cmp_zero_power_en);
	endproperty
	a_en_read: assert property (p_en_read) else $error("enable bit readback wrong");

	property p_ie_write;
		@(posedge sys_clk) disable iff (!resetn)
		sfr_wr && sfr_addr == `CMP_ZERO_MODE_ADDR
		|=> rise_ie_q[0] == $past(sfr_wdata[`MODE_RIE_BIT])
		&& fall_ie_q[0] == $past(sfr_wdata[`MODE_FIE_BIT]);
	endproperty
	a_ie_write: assert property (p_ie_write) else $error("edge enables not written");

	property p_resp_write;
		@(posedge sys_clk) disable iff (!resetn)
		sfr_wr && sfr_addr == `CMP_ONE_MODE_ADDR
		|=> cmp_one_response_sel == $past(sfr_wdata[`MODE_MD_HI:`MODE_MD_LO]);
	endproperty
	a_resp_write: assert property (p_resp_write) else $error("response not written");

	property p_mode_unused;
		@(posedge sys_clk) disable iff (!resetn)
		sfr_rd && (sfr_addr == `CMP_ZERO_MODE_ADDR || sfr_addr == `CMP_ONE_MODE_ADDR)
		|=> sfr_rdata[3:2] == 2'b00;
	endproperty
	a_mode_unused: assert property (p_mode_unused) else $error("mode unused bits set");

	property p_flag_wr_set;
		@(posedge sys_clk) disable iff (!resetn)
		sfr_wr && sfr_addr == `CMP_ZERO_CTRL_ADDR && sfr_wdata[`CTRL_RISE_BIT]
		|=> ctrl_view[0][`CTRL_RISE_BIT];
	endproperty
	a_flag_wr_set: assert property (p_flag_wr_set) else $error("flag write lost");

	property p_raw_off_one;
		@(posedge sys_clk) disable iff (!resetn)
		!cmp_one_power_en |-> !cmp_one_raw_out;
	endproperty
	a_raw_off_one: assert property (p_raw_off_one) else $error("raw one high when off");

	property p_lat_off_one;
		@(posedge sys_clk) disable iff (!resetn)
		!cmp_one_power_en |=> !cmp_one_latched_out;
	endproperty
	a_lat_off_one: assert property (p_lat_off_one) else $error("latched one high when off");

	property p_irq_global;
		@(posedge sys_clk) disable iff (!resetn)
		!global_irq_en |-> !cmp_zero_irq && !cmp_one_irq;
	endproperty
	a_irq_global: assert property (p_irq_global) else $error("request without global");

	property p_irq_src_zero;
		@(posedge sys_clk) disable iff (!resetn)
		!cmp_zero_irq_src_en |-> !cmp_zero_irq;
	endproperty
	a_irq_src_zero: assert property (p_irq_src_zero) else $error("request zero without source");

	property p_irq_src_one;
		@(posedge sys_clk) disable iff (!resetn)
		!cmp_one_irq_src_en |-> !cmp_one_irq;
	endproperty
	a_irq_src_one: assert property (p_irq_src_one) else $error("request one without source");
endmodule

// ==== rtl/cmp_map.svh ====
// Register map, field positions, reset values and levels of the comparator block
`ifndef CMP_MAP_SVH
`define CMP_MAP_SVH
`define CMP_ZERO_CTRL_ADDR 8'h9b
`define CMP_ZERO_MODE_ADDR 8'h9d
`define CMP_ONE_CTRL_ADDR 8'h9a
`define CMP_ONE_MODE_ADDR 8'h9c
`define CTRL_RESET 8'h00
`define MODE_RESET 8'h82
`define CTRL_EN_BIT 7
`define CTRL_STATE_BIT 6
`define CTRL_RISE_BIT 5
`define CTRL_FALL_BIT 4
`define CTRL_HYP_HI 3
`define CTRL_HYP_LO 2
`define CTRL_HYN_HI 1
`define CTRL_HYN_LO 0
`define MODE_RSVD_BIT 7
`define MODE_RIE_BIT 5
`define MODE_FIE_BIT 4
`define MODE_MD_HI 1
`define MODE_MD_LO 0
`define HYST_MV_L0 5'h00
`define HYST_MV_L1 5'h05
`define HYST_MV_L2 5'h0a
`define HYST_MV_L3 5'h14
`endif

// ==== rtl/cmp_pkg.sv ====
// Types shared by the comparator control modules
package cmp_pkg;
`include "cmp_map.svh"
	typedef enum logic [1:0] {RESP_MODE0 = 2'b00, RESP_MODE1 = 2'b01,
		RESP_MODE2 = 2'b10, RESP_MODE3 = 2'b11} resp_mode_e;
	typedef enum logic [1:0] {HYST_OFF = 2'b00, HYST_L1 = 2'b01,
		HYST_L2 = 2'b10, HYST_MAX = 2'b11} hyst_sel_e;
	typedef logic [4:0] hyst_mv_t;
	function automatic hyst_mv_t hyst_mv(input hyst_sel_e sel);
		case (sel)
			HYST_L1: hyst_mv = `HYST_MV_L1;
			HYST_L2: hyst_mv = `HYST_MV_L2;
			HYST_MAX: hyst_mv = `HYST_MV_L3;
			default: hyst_mv = `HYST_MV_L0;
		endcase
	endfunction
endpackage

// ==== rtl/cmp_ctrl_if.sv ====
// Control and status bundle between register file and one comparator channel
`timescale 1ns/1ps
interface cmp_ctrl_if;
	logic enable;
	logic rise_ie;
	logic fall_ie;
	logic flag_wr;
	logic [1:0] flag_wdata;
	logic state;
	logic rise_flag;
	logic fall_flag;
	modport regs (output enable, rise_ie, fall_ie, flag_wr, flag_wdata,
		input state, rise_flag, fall_flag);
	modport chan (input enable, rise_ie, fall_ie, flag_wr, flag_wdata,
		output state, rise_flag, fall_flag);
endinterface

// ==== rtl/cmp_channel.sv ====
// One comparator channel: raw gating, synchroniser, latched output, edge flags, request
`timescale 1ns/1ps
module cmp_channel
	import cmp_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic core_in,
	input wire logic irq_src_en,
	input wire logic global_irq_en,
	cmp_ctrl_if.chan ctl,
	output logic raw_out,
	output logic latched_out,
	output logic irq
);
	logic sync1_q;
	logic sync2_q;
	logic latched_q;
	logic prev_q;
	logic rise_q;
	logic fall_q;
	// ----------------------------------------
	// Output paths
	// ----------------------------------------
	// No flop on the raw path so it still works with the clock stopped
	assign raw_out = ctl.enable & core_in;
	wire latched_d = ctl.enable & sync2_q;
	wire rise_evt = latched_q & ~prev_q;
	wire fall_evt = ~latched_q & prev_q;
	// Set wins over a software clear in the same cycle
	wire rise_d = rise_evt | (ctl.flag_wr ? ctl.flag_wdata[1] : rise_q);
	wire fall_d = fall_evt | (ctl.flag_wr ? ctl.flag_wdata[0] : fall_q);
	wire flag_req = (rise_q & ctl.rise_ie) | (fall_q & ctl.fall_ie);
	assign irq = flag_req & irq_src_en & global_irq_en;
	assign latched_out = latched_q;
	assign ctl.state = latched_q;
	assign ctl.rise_flag = rise_q;
	assign ctl.fall_flag = fall_q;
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end
		else
		begin
			sync1_q <= core_in;
			sync2_q <= sync1_q;
		end
	end
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			latched_q <= 1'b0;
			prev_q <= 1'b0;
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end
		else
		begin
			latched_q <= latched_d;
			prev_q <= latched_q;
			rise_q <= rise_d;
			fall_q <= fall_d;
		end
	end
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_latch_follow;
		@(posedge sys_clk) disable iff (!resetn)
		ctl.enable && sync2_q |=> latched_out;
	endproperty
	a_latch_follow: assert property (p_latch_follow) else $error("latched lost");
	property p_off_low;
		@(posedge sys_clk) disable iff (!resetn)
		!ctl.enable |-> !raw_out ##1 !latched_out;
	endproperty
	a_off_low: assert property (p_off_low) else $error("disabled output high");
	property p_rise_set;
		@(posedge sys_clk) disable iff (!resetn)
		$rose(latched_q) && !fall_q && !ctl.flag_wr |=> rise_q && !fall_q;
	endproperty
	a_rise_set: assert property (p_rise_set) else $error("rise flag missed");
	property p_fall_set;
		@(posedge sys_clk) disable iff (!resetn)
		$fell(latched_q) |=> fall_q;
	endproperty
	a_fall_set: assert property (p_fall_set) else $error("fall flag missed");
	property p_sticky;
		@(posedge sys_clk) disable iff (!resetn)
		!ctl.flag_wr |=> (rise_q || !$past(rise_q)) && (fall_q || !$past(fall_q));
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag dropped");
	property p_irq_gate;
		@(posedge sys_clk) disable iff (!resetn)
		irq |-> irq_src_en && global_irq_en && (rise_q && ctl.rise_ie || fall_q && ctl.fall_ie);
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("request not gated");
endmodule

// ==== sim/cmp_core_model.sv ====
// Behavioural analog comparator core with hysteresis, one per channel
`timescale 1ns/1ps
module cmp_core_model
	import cmp_pkg::*;
(
	input wire logic power_en,
	input wire hyst_mv_t pos_mv,
	input wire hyst_mv_t neg_mv,
	input wire logic [11:0] vplus,
	input wire logic [11:0] vminus,
	output logic core_out
);
	logic out_q = 1'b0;
	// Level-sensitive on purpose: the real core needs no clock
	always @(power_en or vplus or vminus or pos_mv or neg_mv)
	begin
		if (!power_en)
			out_q = 1'b0;
		else if (!out_q && vplus > vminus + pos_mv)
			out_q = 1'b1;
		else if (out_q && vplus + neg_mv < vminus)
			out_q = 1'b0;
	end
	assign core_out = out_q;
endmodule

// ==== sim/dual_comparator_control_tb.sv ====
// Self-checking bench for the dual comparator control block
`timescale 1ns/1ps
module dual_comparator_control_tb;
	import cmp_pkg::*;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
	logic sfr_wr = 1'b0, sfr_rd = 1'b0, global_irq_en = 1'b1;
	logic src_en [2] = '{1'b1, 1'b1};
	logic [11:0] vp [2] = '{12'h190, 12'h190};
	logic z_core, o_core, z_pwr, o_pwr, z_lat, o_lat, z_raw, o_raw, z_irq, o_irq;
	resp_mode_e z_resp, o_resp;
	hyst_mv_t z_pmv, z_nmv, o_pmv, o_nmv;
	int mismatches = 0, comparisons = 0;
	logic ch = 1'b0;
	logic [7:0] ca [2] = '{8'h9b, 8'h9a};
	logic [7:0] ma [2] = '{8'h9d, 8'h9c};
	wire raw_w = ch ? o_raw : z_raw;
	wire lat_w = ch ? o_lat : z_lat;
	wire irq_w = ch ? o_irq : z_irq;
	wire pwr_w = ch ? o_pwr : z_pwr;
	wire [1:0] resp_w = ch ? o_resp : z_resp;
	wire [4:0] pmv_w = ch ? o_pmv : z_pmv;
	wire [4:0] nmv_w = ch ? o_nmv : z_nmv;

	always #10 sys_clk = ~sys_clk;

	dual_comparator_control dut_u (.sys_clk(sys_clk), .resetn(resetn), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
		.global_irq_en(global_irq_en), .cmp_zero_irq_src_en(src_en[0]),
		.cmp_one_irq_src_en(src_en[1]), .cmp_zero_core_in(z_core), .cmp_one_core_in(o_core),
		.cmp_zero_power_en(z_pwr), .cmp_one_power_en(o_pwr), .cmp_zero_response_sel(z_resp),
		.cmp_one_response_sel(o_resp), .cmp_zero_pos_hyst_mv(z_pmv),
		.cmp_zero_neg_hyst_mv(z_nmv), .cmp_one_pos_hyst_mv(o_pmv), .cmp_one_neg_hyst_mv(o_nmv),
		.cmp_zero_latched_out(z_lat), .cmp_one_latched_out(o_lat), .cmp_zero_raw_out(z_raw),
		.cmp_one_raw_out(o_raw), .cmp_zero_irq(z_irq), .cmp_one_irq(o_irq));
	cmp_core_model core_zero_u (.power_en(z_pwr), .pos_mv(z_pmv), .neg_mv(z_nmv),
		.vplus(vp[0]), .vminus(12'h1f4), .core_out(z_core));
	cmp_core_model core_one_u (.power_en(o_pwr), .pos_mv(o_pmv), .neg_mv(o_nmv),
		.vplus(vp[1]), .vminus(12'h1f4), .core_out(o_core));

	// ----------------------------------------
	// Bench helpers
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Strobe drops one cycle before the next request may raise it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		tick(1);
		sfr_wr = 1'b0;
		tick(1);
	endtask
	task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
		sfr_addr = a;
		sfr_rd = 1'b1;
		tick(1);
		sfr_rd = 1'b0;
		check(name, sfr_rdata, exp);
		tick(1);
	endtask
	function automatic logic [4:0] hmv(input logic [1:0] c);
		return (c == 2'd0) ? 5'h00 : (c == 2'd1) ? 5'h05 : (c == 2'd2) ? 5'h0a : 5'h14;
	endfunction
	function automatic logic [7:0] exp_mode(input logic [7:0] w);
		return {2'b10, w[5:4], 2'b00, w[1:0]};
	endfunction
	task automatic end_of_test;
		if (mismatches == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial
	begin
		#200000;
		mismatches++;
		end_of_test;
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		logic [7:0] w;
		void'($urandom(40675));
		tick(5);
		resetn = 1'b1;
		tick(1);
		rd_chk("ctrl_zero_rst", 8'h9b, 8'h00);
		rd_chk("ctrl_one_rst", 8'h9a, 8'h00);
		rd_chk("mode_zero_rst", 8'h9d, 8'h82);
		rd_chk("mode_one_rst", 8'h9c, 8'h82);
		rd_chk("unmapped", 8'h9e, 8'h00);
		for (int c = 0; c < 2; c++)
		begin
			ch = c[0];
			tick(1);
			check("resp_rst", resp_w, 8'h02);
			wr(ma[ch], 8'hb0);
			wr(ca[ch], 8'h80);
			check("power_on", pwr_w, 8'h01);
			tick(4);
			wr(ca[ch], 8'h80);
			rd_chk("ctrl_clean", ca[ch], 8'h80);
			vp[ch] = 12'h208;
			#1;
			check("raw_rise", raw_w, 8'h01);
			tick(2);
			check("lat_early", lat_w, 8'h00);
			tick(1);
			check("lat_rise", lat_w, 8'h01);
			tick(1);
			check("irq_rise", irq_w, 8'h01);
			global_irq_en = 1'b0;
			tick(1);
			check("irq_global", irq_w, 8'h00);
			global_irq_en = 1'b1;
			src_en[ch] = 1'b0;
			tick(1);
			check("irq_src", irq_w, 8'h00);
			src_en[ch] = 1'b1;
			wr(ma[ch], 8'h90);
			check("irq_rie_off", irq_w, 8'h00);
			rd_chk("ctrl_risen", ca[ch], 8'he0);
			vp[ch] = 12'h1e0;
			tick(4);
			rd_chk("ctrl_fallen", ca[ch], 8'hb0);
			check("irq_fall", irq_w, 8'h01);
			wr(ca[ch], 8'ha0);
			rd_chk("clr_fall", ca[ch], 8'ha0);
			check("irq_cleared", irq_w, 8'h00);
			wr(ca[ch], 8'h8f);
			check("pos_mv_max", pmv_w, 8'h14);
			check("neg_mv_max", nmv_w, 8'h14);
			vp[ch] = 12'h1fe;
			tick(4);
			check("hyst_hold_low", lat_w, 8'h00);
			vp[ch] = 12'h20d;
			tick(4);
			check("hyst_rise", lat_w, 8'h01);
			vp[ch] = 12'h1ea;
			tick(4);
			check("hyst_hold_high", lat_w, 8'h01);
			vp[ch] = 12'h1db;
			tick(4);
			check("hyst_fall", lat_w, 8'h00);
			vp[ch] = 12'h20d;
			tick(4);
			wr(ca[ch], 8'h00);
			check("raw_off", raw_w, 8'h00);
			check("power_off", pwr_w, 8'h00);
			tick(4);
			check("lat_off", lat_w, 8'h00);
			rd_chk("ctrl_off", ca[ch], 8'h10);
			wr(ca[ch], 8'h00);
			vp[ch] = 12'h190;
			for (int m = 0; m < 4; m++)
			begin
				wr(ma[ch], 8'h80 | m[7:0]);
				check("resp_sel", resp_w, m[7:0]);
				wr(ca[ch], {4'h0, m[1:0], ~m[1:0]});
				check("pos_mv", pmv_w, hmv(m[1:0]));
				check("neg_mv", nmv_w, hmv(~m[1:0]));
			end
			wr(ma[ch], 8'h7f);
			rd_chk("mode_rsvd", ma[ch], 8'hb3);
			repeat (12)
			begin
				w = 8'($urandom);
				wr(ma[ch], w);
				rd_chk("mode_rand", ma[ch], exp_mode(w));
				check("resp_rand", resp_w, w & 8'h03);
				w = 8'($urandom);
				wr(ca[ch], w & 8'h8f);
				rd_chk("ctrl_rand", ca[ch], w & 8'h8f);
				check("pmv_rand", pmv_w, hmv(w[3:2]));
				check("nmv_rand", nmv_w, hmv(w[1:0]));
			end
			wr(ca[ch], 8'h00);
		end
		end_of_test;
	end
endmodule
